// [inc/fbg_pkg.sv]
package fbg_pkg;

  // Number of serial channels, each with its own generator.
  localparam int CHANNELS = 8;

  // Avalon word address layout: channel in the upper bits, register below.
  localparam int ADDR_W = 6;
  localparam int REG_W = 3;
  localparam int CHAN_W = 3;
  localparam int DATA_W = 32;
  localparam int BE_W = 4;

  // Register indices within a channel; byte address is four times the word address.
  localparam logic [REG_W-1:0] REG_DIV_LOW = 3'h0;
  localparam logic [REG_W-1:0] REG_DIV_HIGH = 3'h1;
  localparam logic [REG_W-1:0] REG_DIV_FRAC = 3'h2;
  localparam logic [REG_W-1:0] REG_MODEM_CTRL = 3'h3;
  localparam logic [REG_W-1:0] REG_EIGHT_SEL = 3'h4;
  localparam logic [REG_W-1:0] REG_FOUR_SEL = 3'h5;
  localparam logic [REG_W-1:0] REG_STATUS = 3'h6;

  // Reset values.
  localparam logic [7:0] RST_DIV_LOW = 8'h01;
  localparam logic [7:0] RST_DIV_HIGH = 8'h00;
  localparam logic [3:0] RST_DIV_FRAC = 4'h0;
  localparam logic [7:0] RST_MODEM_CTRL = 8'h00;
  localparam logic [7:0] RST_MODE_SEL = 8'h00;

  // Field positions and codes.
  localparam int PRESCALE_BIT = 7;
  localparam int FRAC_W = 4;
  localparam logic [7:0] MODE_SEL_ON = 8'hFF;
  localparam logic [7:0] MODE_SEL_OFF = 8'h00;
  localparam int ST_PRESCALE_BIT = 0;
  localparam int ST_MODE_LSB = 1;
  localparam int ST_RESERVED_BIT = 3;
  localparam int ST_PHASE_LSB = 4;

  // Prescaler: divide by four means a tick when the count reaches three.
  localparam logic [1:0] PRESCALE_LAST = 2'h3;

  // Sampling clock periods per serial bit.
  localparam logic [4:0] SAMPLES_16X = 5'h10;
  localparam logic [4:0] SAMPLES_8X = 5'h08;
  localparam logic [4:0] SAMPLES_4X = 5'h04;

  typedef enum logic [1:0] {
    MODE_16X,
    MODE_8X,
    MODE_4X
  } fbg_mode_t;

endpackage

// [rtl/fbg_prescaler.sv]
`timescale 1ns/1ps
module fbg_prescaler (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic divideByFour,
  output logic prescaleTick
);
  import fbg_pkg::*;

  logic [1:0] count;
  logic [1:0] next_count;
  logic next_prescaleTick;

  // Passes every clock when dividing by one, every fourth clock otherwise.
  always_comb begin
    next_count = count + 2'h1;
    next_prescaleTick = 1'b0;
    if (!divideByFour) begin
      next_count = 2'h0;
      next_prescaleTick = 1'b1;
    end else if (count == PRESCALE_LAST) begin
      next_count = 2'h0;
      next_prescaleTick = 1'b1;
    end
  end

  // Registers the prescaler state.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      count <= 2'h0;
      prescaleTick <= 1'b0;
    end else begin
      count <= next_count;
      prescaleTick <= next_prescaleTick;
    end
  end

endmodule

// [rtl/fbg_frac_divider.sv]
`timescale 1ns/1ps
module fbg_frac_divider (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic prescaleTick,
  input wire logic [15:0] intDivisor,
  input wire logic [fbg_pkg::FRAC_W-1:0] fracDivisor,
  output logic sampleTick,
  output logic [fbg_pkg::FRAC_W-1:0] fracPhase
);
  import fbg_pkg::*;

  logic [16:0] count;
  logic [16:0] next_count;
  logic stretch;
  logic next_stretch;
  logic [FRAC_W-1:0] next_fracPhase;
  logic next_sampleTick;
  logic [16:0] effInt;
  logic [16:0] periodLen;
  logic [FRAC_W:0] phaseSum;

  // Counts prescaled ticks; a zero integer part acts as one. The phase
  // accumulator carries out on exactly fracDivisor of every sixteen periods,
  // and each carry lengthens the next period by one prescaled tick.
  always_comb begin
    effInt = (intDivisor == 16'h0000) ? 17'h00001 : {1'b0, intDivisor};
    periodLen = effInt + {16'h0000, stretch};
    phaseSum = {1'b0, fracPhase} + {1'b0, fracDivisor};
    next_count = count;
    next_stretch = stretch;
    next_fracPhase = fracPhase;
    next_sampleTick = 1'b0;
    if (prescaleTick) begin
      if (count + 17'h00001 >= periodLen) begin
        next_count = 17'h00000;
        next_sampleTick = 1'b1;
        next_fracPhase = phaseSum[FRAC_W-1:0];
        next_stretch = phaseSum[FRAC_W];
      end else begin
        next_count = count + 17'h00001;
      end
    end
  end

  // Registers the divider state.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      count <= 17'h00000;
      stretch <= 1'b0;
      fracPhase <= '0;
      sampleTick <= 1'b0;
    end else begin
      count <= next_count;
      stretch <= next_stretch;
      fracPhase <= next_fracPhase;
      sampleTick <= next_sampleTick;
    end
  end

endmodule

// [rtl/fbg_top.sv]
`timescale 1ns/1ps
module fbg_top (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [fbg_pkg::ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [fbg_pkg::DATA_W-1:0] writedata,
  input wire logic [fbg_pkg::BE_W-1:0] byteenable,
  output logic [fbg_pkg::DATA_W-1:0] readdata,
  output logic waitrequest,
  output logic [fbg_pkg::CHANNELS-1:0] sampleTick,
  output logic [fbg_pkg::CHANNELS-1:0] bitTick
);
  import fbg_pkg::*;

  // Per-channel register file.
  logic [7:0] divLow [CHANNELS];
  logic [7:0] divHigh [CHANNELS];
  logic [FRAC_W-1:0] divFrac [CHANNELS];
  logic [7:0] modemCtrl [CHANNELS];
  logic [7:0] eightSel [CHANNELS];
  logic [7:0] fourSel [CHANNELS];
  logic [7:0] next_divLow [CHANNELS];
  logic [7:0] next_divHigh [CHANNELS];
  logic [FRAC_W-1:0] next_divFrac [CHANNELS];
  logic [7:0] next_modemCtrl [CHANNELS];
  logic [7:0] next_eightSel [CHANNELS];
  logic [7:0] next_fourSel [CHANNELS];

  // Bus slave state.
  logic next_waitrequest;
  logic [DATA_W-1:0] next_readdata;
  logic [CHAN_W-1:0] selChan;
  logic [REG_W-1:0] selReg;
  logic writeTaken;

  // Per-channel generator state, seen by the register file except prescaleTick.
  fbg_mode_t chanMode [CHANNELS];
  logic [CHANNELS-1:0] modeReserved;
  logic [FRAC_W-1:0] fracPhase [CHANNELS];
  logic [CHANNELS-1:0] prescaleTick;

  // Decode of the word address into channel and register.
  assign selChan = address[ADDR_W-1:REG_W];
  assign selReg = address[REG_W-1:0];
  assign writeTaken = write && !waitrequest && byteenable[0];

  // Register writes land at the edge where waitrequest is seen low.
  always_comb begin
    for (int c = 0; c < CHANNELS; c++) begin
      next_divLow[c] = divLow[c];
      next_divHigh[c] = divHigh[c];
      next_divFrac[c] = divFrac[c];
      next_modemCtrl[c] = modemCtrl[c];
      next_eightSel[c] = eightSel[c];
      next_fourSel[c] = fourSel[c];
      if (writeTaken && (selChan == c[CHAN_W-1:0])) begin
        unique case (selReg)
          REG_DIV_LOW: next_divLow[c] = writedata[7:0];
          REG_DIV_HIGH: next_divHigh[c] = writedata[7:0];
          REG_DIV_FRAC: next_divFrac[c] = writedata[FRAC_W-1:0];
          REG_MODEM_CTRL: next_modemCtrl[c] = writedata[7:0];
          REG_EIGHT_SEL: next_eightSel[c] = writedata[7:0];
          REG_FOUR_SEL: next_fourSel[c] = writedata[7:0];
          default: begin
          end
        endcase
      end
    end
  end

  // Registers the register file; the divisor comes out of reset as one.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int c = 0; c < CHANNELS; c++) begin
        divLow[c] <= RST_DIV_LOW;
        divHigh[c] <= RST_DIV_HIGH;
        divFrac[c] <= RST_DIV_FRAC;
        modemCtrl[c] <= RST_MODEM_CTRL;
        eightSel[c] <= RST_MODE_SEL;
        fourSel[c] <= RST_MODE_SEL;
      end
    end else begin
      for (int c = 0; c < CHANNELS; c++) begin
        divLow[c] <= next_divLow[c];
        divHigh[c] <= next_divHigh[c];
        divFrac[c] <= next_divFrac[c];
        modemCtrl[c] <= next_modemCtrl[c];
        eightSel[c] <= next_eightSel[c];
        fourSel[c] <= next_fourSel[c];
      end
    end
  end

  // Avalon handshake: a request seen with waitrequest high is answered by
  // dropping waitrequest for exactly one cycle, with read data already
  // loaded, so every access takes two cycles. Unmapped reads return zero.
  always_comb begin
    next_waitrequest = 1'b1;
    next_readdata = readdata;
    if ((read || write) && waitrequest) begin
      next_waitrequest = 1'b0;
      next_readdata = '0;
      if (read) begin
        unique case (selReg)
          REG_DIV_LOW: next_readdata[7:0] = divLow[selChan];
          REG_DIV_HIGH: next_readdata[7:0] = divHigh[selChan];
          REG_DIV_FRAC: next_readdata[FRAC_W-1:0] = divFrac[selChan];
          REG_MODEM_CTRL: next_readdata[7:0] = modemCtrl[selChan];
          REG_EIGHT_SEL: next_readdata[7:0] = eightSel[selChan];
          REG_FOUR_SEL: next_readdata[7:0] = fourSel[selChan];
          REG_STATUS: begin
            next_readdata[ST_PRESCALE_BIT] = modemCtrl[selChan][PRESCALE_BIT];
            next_readdata[ST_MODE_LSB +: 2] = chanMode[selChan];
            next_readdata[ST_RESERVED_BIT] = modeReserved[selChan];
            next_readdata[ST_PHASE_LSB +: FRAC_W] = fracPhase[selChan];
          end
          default: begin
          end
        endcase
      end
    end
  end

  // Registers the bus answer.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      waitrequest <= 1'b1;
      readdata <= '0;
    end else begin
      waitrequest <= next_waitrequest;
      readdata <= next_readdata;
    end
  end

  // One independent generator per channel, all on the same system clock.
  for (genvar g = 0; g < CHANNELS; g++) begin : gen_chan
    logic [4:0] sampCount;
    logic [4:0] next_sampCount;
    logic next_bitTick;
    logic [4:0] samplesPerBit;

    // Prescaler stage ahead of the divisor.
    fbg_prescaler u_prescaler (
      .clk(clk),
      .reset_n(reset_n),
      .divideByFour(modemCtrl[g][PRESCALE_BIT]),
      .prescaleTick(prescaleTick[g])
    );

    // Fractional divisor stage; it paces the sampling clock.
    fbg_frac_divider u_divider (
      .clk(clk),
      .reset_n(reset_n),
      .prescaleTick(prescaleTick[g]),
      .intDivisor({divHigh[g], divLow[g]}),
      .fracDivisor(divFrac[g]),
      .sampleTick(sampleTick[g]),
      .fracPhase(fracPhase[g])
    );

    // Sampling mode decode; the reserved pair falls back to 16X and is
    // flagged in status. In 8X an odd fraction lets a bit absorb an uneven
    // number of stretched periods, a jitter of one prescaled tick.
    always_comb begin
      chanMode[g] = MODE_16X;
      modeReserved[g] = 1'b0;
      if (eightSel[g] == MODE_SEL_ON && fourSel[g] == MODE_SEL_OFF) begin
        chanMode[g] = MODE_8X;
      end else if (fourSel[g] == MODE_SEL_ON && eightSel[g] == MODE_SEL_OFF) begin
        chanMode[g] = MODE_4X;
      end else if (fourSel[g] == MODE_SEL_ON && eightSel[g] == MODE_SEL_ON) begin
        modeReserved[g] = 1'b1;
      end
      unique case (chanMode[g])
        MODE_8X: samplesPerBit = SAMPLES_8X;
        MODE_4X: samplesPerBit = SAMPLES_4X;
        default: samplesPerBit = SAMPLES_16X;
      endcase
    end

    // Bit timing: one bit per 16, 8 or 4 sampling ticks.
    always_comb begin
      next_sampCount = sampCount;
      next_bitTick = 1'b0;
      if (sampleTick[g]) begin
        if (sampCount + 5'h01 >= samplesPerBit) begin
          next_sampCount = 5'h00;
          next_bitTick = 1'b1;
        end else begin
          next_sampCount = sampCount + 5'h01;
        end
      end
    end

    // Registers the bit timing.
    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        sampCount <= 5'h00;
        bitTick[g] <= 1'b0;
      end else begin
        sampCount <= next_sampCount;
        bitTick[g] <= next_bitTick;
      end
    end
  end

endmodule

// [verification/fbg_osc_model.sv]
`timescale 1ns/1ps
// Oscillator that clocks all channel generators of the block.
module fbg_osc_model (
  output logic clk
);
  // Starts low and toggles each half period of 5 ns.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
endmodule

// [verification/fbg_top_monitor.sv]
`timescale 1ns/1ps
// Watches the register bus and the tick outputs at the block's ports.
module fbg_top_monitor (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [fbg_pkg::ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [fbg_pkg::DATA_W-1:0] readdata,
  input wire logic waitrequest,
  input wire logic [fbg_pkg::CHANNELS-1:0] sampleTick,
  input wire logic [fbg_pkg::CHANNELS-1:0] bitTick
);
  import fbg_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // A taken request is answered at the next edge, for one cycle only.
  a_read_answer: assert property (read && waitrequest |=> !waitrequest)
    else $error("read not answered");
  a_write_answer: assert property (write && waitrequest |=> !waitrequest)
    else $error("write not answered");
  a_wait_single: assert property (!waitrequest |=> waitrequest)
    else $error("answer too long");
  a_wait_idle: assert property (!read && !write && waitrequest |=> waitrequest)
    else $error("answer without request");
  // Read data carry only the implemented bits.
  a_read_upper: assert property (read && !waitrequest |-> readdata[31:8] == 24'h0)
    else $error("upper read bits set");
  a_frac_bits: assert property (read && waitrequest && address[2:0] == REG_DIV_FRAC
    |=> readdata[7:4] == 4'h0) else $error("fraction upper bits set");
  a_hole_zero: assert property (read && waitrequest && address[2:0] == 3'h7
    |=> readdata == 32'h0) else $error("unmapped read not zero");
  // On channel 0, four or more sampling ticks of a cycle or more lie between bit ticks.
  a_bit_spacing: assert property (bitTick[0] |=> !bitTick[0] [*3])
    else $error("bit ticks too close");
  c_read_done: cover property (read && !waitrequest);
  c_write_done: cover property (write && !waitrequest);
  c_bit_tick: cover property (bitTick[7]);
  c_sample: cover property (sampleTick[3]);
endmodule

bind fbg_top fbg_top_monitor fbg_top_monitor_inst (.clk(clk), .reset_n(reset_n),
  .address(address), .read(read), .write(write), .readdata(readdata),
  .waitrequest(waitrequest), .sampleTick(sampleTick), .bitTick(bitTick));

// [verification/fractional_baud_generator_tb.sv]
`timescale 1ns/1ps
module fractional_baud_generator_tb;
  import fbg_pkg::*;
  logic clk;
  logic reset_n;
  logic [ADDR_W-1:0] address;
  logic read;
  logic write;
  logic [DATA_W-1:0] writedata;
  logic [BE_W-1:0] byteenable;
  logic [DATA_W-1:0] readdata;
  logic waitrequest;
  logic [CHANNELS-1:0] sampleTick;
  logic [CHANNELS-1:0] bitTick;
  logic [31:0] q;
  int fails = 0;
  int checks_done = 0;
  int cycles = 0;

  fbg_osc_model fbg_osc_model_inst (.clk(clk));
  fbg_top fbg_top_inst (.clk(clk), .reset_n(reset_n), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .sampleTick(sampleTick), .bitTick(bitTick));

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One bus access, held until waitrequest is seen low at an edge.
  task automatic busOp(input logic w, input logic [2:0] ch, input logic [2:0] idx,
                       input logic [7:0] d, input logic be);
    @(posedge clk);
    address <= {ch, idx};
    writedata <= {24'h0, d};
    byteenable <= {3'h0, be};
    write <= w;
    read <= !w;
    do @(posedge clk); while (waitrequest !== 1'b0);
    q = readdata;
    write <= 1'b0;
    read <= 1'b0;
  endtask

  // Times the third bit period of a channel and counts its sampling ticks.
  task automatic meas(input logic [2:0] ch, input logic [31:0] cyc, input logic [31:0] spb);
    logic [31:0] n;
    logic [31:0] s;
    n = 0;
    s = 0;
    repeat (2) begin
      do @(posedge clk); while (bitTick[ch] !== 1'b1);
    end
    do begin
      @(posedge clk);
      n++;
      s = s + {31'h0, sampleTick[ch]};
    end while (bitTick[ch] !== 1'b1);
    chk(n, cyc);
    chk(s, spb);
  endtask

  // Loads low, high, fraction, control and both selects, then times a bit.
  task automatic rate(input logic [2:0] ch, input logic [47:0] cfg, input logic [31:0] cyc,
                      input logic [31:0] spb);
    for (int i = 0; i < 6; i++) begin
      busOp(1'b1, ch, i[2:0], cfg[47-8*i -: 8], 1'b1);
    end
    meas(ch, cyc, spb);
  endtask

  task automatic test_reset();
    for (int i = 0; i < 6; i++) begin
      busOp(1'b0, 3'h0, i[2:0], 8'h00, 1'b0);
      chk(q, (i == 0) ? 32'h1 : 32'h0);
    end
    meas(3'h0, 32'h10, 32'h10);
    $display("reset test done");
  endtask

  task automatic test_rates();
    rate(3'h0, 48'h03_00_00_00_00_00, 32'h30, 32'h10);
    rate(3'h1, 48'h03_00_00_00_FF_00, 32'h18, 32'h08);
    rate(3'h2, 48'h03_00_00_00_00_FF, 32'h0C, 32'h04);
    rate(3'h3, 48'h03_00_00_80_00_FF, 32'h30, 32'h04);
    rate(3'h4, 48'h00_01_00_00_00_FF, 32'h400, 32'h04);
    rate(3'h5, 48'h01_00_08_00_00_00, 32'h18, 32'h10);
    rate(3'h6, 48'h02_00_0F_00_00_00, 32'h2F, 32'h10);
    rate(3'h7, 48'h04_00_04_00_FF_00, 32'h22, 32'h08);
    rate(3'h0, 48'h03_00_00_00_FF_FF, 32'h30, 32'h10);
    meas(3'h1, 32'h18, 32'h08);
    $display("rate test done");
  endtask

  task automatic test_bus();
    busOp(1'b1, 3'h2, REG_DIV_FRAC, 8'hFF, 1'b1);
    busOp(1'b0, 3'h2, REG_DIV_FRAC, 8'h00, 1'b0);
    chk(q, 32'h0F);
    busOp(1'b1, 3'h2, REG_DIV_LOW, 8'h55, 1'b0);
    busOp(1'b0, 3'h2, REG_DIV_LOW, 8'h00, 1'b0);
    chk(q, 32'h03);
    busOp(1'b0, 3'h2, 3'h7, 8'h00, 1'b0);
    chk(q, 32'h00);
    // A write to the read-only status index must leave the channel untouched.
    busOp(1'b1, 3'h3, REG_STATUS, 8'hFF, 1'b1);
    busOp(1'b0, 3'h3, REG_STATUS, 8'h00, 1'b0);
    chk({28'h0, q[3:0]}, 32'h5);
    // Channel 0 was left with both selects set: 16X with the reserved flag.
    busOp(1'b0, 3'h0, REG_STATUS, 8'h00, 1'b0);
    chk({28'h0, q[3:0]}, 32'h8);
    $display("bus test done");
  endtask

  // Ends a hung run as a failure.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      fails++;
      end_sim();
    end
  end

  // Resets for ten cycles, then runs every scenario.
  initial begin
    reset_n = 1'b0;
    address = '0;
    read = 1'b0;
    write = 1'b0;
    writedata = '0;
    byteenable = '0;
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    test_reset();
    test_rates();
    test_bus();
    end_sim();
  end
endmodule
